// >>> hw/ptf_regs.vh
// constants for the pmbus target framing block: register map, fields, command codes
// assumes byte addresses on the avalon slave, one 32-bit word per register
`ifndef PTF_REGS_VH
`define PTF_REGS_VH

`define PTF_REG_CTRL        6'h00
`define PTF_REG_STATUS      6'h01
`define PTF_REG_IRQ_STATUS  6'h02
`define PTF_REG_IRQ_CLEAR   6'h03
`define PTF_REG_IRQ_ENABLE  6'h04
`define PTF_REG_RX_CMD      6'h05
`define PTF_REG_VOUT_VALUE  6'h06
`define PTF_REG_FAN_RAW     6'h07
`define PTF_REG_FAN_VALUE   6'h08
`define PTF_REG_TEMP        6'h09
`define PTF_REG_FAN1        6'h0A
`define PTF_REG_FAN2        6'h0B
`define PTF_REG_OPERATION   6'h0C

`define PTF_OWN_ADDR_RST    7'h58
`define PTF_OPERATION_RST   8'h00

`define PTF_ST_OUTPUT_ON    0
`define PTF_ST_OVERCURRENT  1
`define PTF_ST_SHUTDOWN     2
`define PTF_ST_PEC_ERR      3
`define PTF_ST_UNSUPPORTED  4
`define PTF_ST_REMOTE_PIN   5
`define PTF_ST_WIDTH        6

`define PTF_IRQ_WRITE       0
`define PTF_IRQ_PEC_ERR     1
`define PTF_IRQ_UNSUPPORTED 2
`define PTF_IRQ_ALARM       3
`define PTF_IRQ_CLEAR_FLT   4
`define PTF_IRQ_WIDTH       5

`define PTF_CMD_OPERATION   8'h01
`define PTF_CMD_ONOFF_CFG   8'h02
`define PTF_CMD_CLEAR_FLT   8'h03
`define PTF_CMD_CAPABILITY  8'h19
`define PTF_CMD_VOUT_MODE   8'h20
`define PTF_CMD_VOUT_CMD    8'h21
`define PTF_CMD_FAN_CMD     8'h3B
`define PTF_CMD_TEMP        8'h8F
`define PTF_CMD_FAN1        8'h90
`define PTF_CMD_FAN2        8'h91
`define PTF_CMD_PMB_REV     8'h98
`define PTF_CMD_ALARM_BLK   8'hD2

`define PTF_LEN_NONE        3'h7
`define PTF_ALARM_BLK_CNT   8'h04
`define PTF_VOUT_EXP        9
`define PTF_VOUT_MODE_VAL   8'h09
`define PTF_OPER_ON_BIT     7
`define PTF_CRC_POLY        8'h07

`endif

// >>> hw/ptf_crc8.v
// running crc-8 (x^8+x^2+x+1) over every byte marked by valid since the last clear
// assumes clear and valid come from logic on the same clock, never together with effect
`timescale 1ns/100ps
`include "ptf_regs.vh"

module ptf_crc8 (
	input  wire       clock,
	input  wire       rst_n,
	input  wire       clear,
	input  wire       valid,
	input  wire [7:0] data,
	output reg  [7:0] crc
);

	function [7:0] crc_byte;
		input [7:0] c;
		input [7:0] d;
		integer     i;
		reg   [7:0] r;
		begin
			r = c ^ d;
			for (i = 0; i < 8; i = i + 1) begin
				r = r[7] ? ((r << 1) ^ `PTF_CRC_POLY) : (r << 1);
			end
			crc_byte = r;
		end
	endfunction

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			crc <= 8'h00;
		end else if (clear) begin
			crc <= 8'h00;
		end else if (valid) begin
			crc <= crc_byte(crc, data);
		end
	end

endmodule // ptf_crc8

// >>> hw/ptf_target.v
// pmbus target framing: two-wire bus slave, command decode, status latching, avalon registers
// assumes scl and sda come from pins (sampled here), fault inputs from logic on clock
//
// How it works
// (R1) standard write: command plus at most two bytes
// (R2) multi-byte values go low byte first
// (R3) every frame ends with pec over all bytes
// (R4) read: command write, restart, data, pec, nack
// (R5) more than two bytes use byte-count block framing
// (R6) linear word: 5-bit exponent, 11-bit mantissa
// (R7) linear value is mantissa times two^exponent
// (R8) all quantities linear except output voltage
// (R9) output voltage: 16-bit mantissa, fixed exponent
// (R10) output on needs remote pin and operation
// (R11) on/off config, capability, revision not readable
// (R12) output-on status bit tracks live state
// (R13) alarm bits latch until clear_faults
// (R14) clear_faults clears all; live faults reset
// (R15) pec is crc-8 x^8+x^2+x+1, address included
// (R16) commands without pec are ignored
// (R17) supplier of last data byte appends pec
// (R18) unsupported read returns zero and flags
// (R19) bad pec discards write, flags comm error
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
`include "ptf_regs.vh"

module ptf_target (
	input  wire        clock,
	input  wire        rst_n,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	output reg         irq,
	input  wire        scl_in,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe,
	input  wire        remote_onoff_pin,
	input  wire        overcurrent_fault_live,
	input  wire        shutdown_live,
	output reg         output_on
);

	// write data length per command, none when not writable
	function [2:0] wr_len;
		input [7:0] c;
		begin
			case (c)
				`PTF_CMD_CLEAR_FLT: wr_len = 3'h0;
				`PTF_CMD_OPERATION: wr_len = 3'h1;
				`PTF_CMD_VOUT_CMD:  wr_len = 3'h2;
				`PTF_CMD_FAN_CMD:   wr_len = 3'h2;
				default:            wr_len = `PTF_LEN_NONE;
			endcase
		end
	endfunction

	// read length per command, none when not readable
	function [2:0] rd_len;
		input [7:0] c;
		begin
			case (c)
				`PTF_CMD_OPERATION: rd_len = 3'h1;
				`PTF_CMD_VOUT_MODE: rd_len = 3'h1;
				`PTF_CMD_VOUT_CMD:  rd_len = 3'h2;
				`PTF_CMD_TEMP:      rd_len = 3'h2;
				`PTF_CMD_FAN1:      rd_len = 3'h2;
				`PTF_CMD_FAN2:      rd_len = 3'h2;
				`PTF_CMD_ALARM_BLK: rd_len = 3'h5;
				default:            rd_len = `PTF_LEN_NONE;
			endcase
		end
	endfunction

	// linear word to integer value, fraction truncated
	function [31:0] lin_value;
		input [15:0] w;
		reg signed [31:0] m;
		reg        [4:0]  e;
		begin
			m = {{21{w[10]}}, w[10:0]};
			e = w[15:11];
			if (e[4])
				lin_value = m >>> (5'h00 - e);
			else
				lin_value = m <<< e;
		end
	endfunction

	reg        rst_s1;
	reg        rst_s2;
	reg        scl_s1, scl_s2, scl_s3;
	reg        sda_s1, sda_s2, sda_s3;
	reg        pin_s1, pin_s2;
	wire       rstn_i = rst_s2;
	wire       scl_rise = scl_s2 & ~scl_s3;
	wire       scl_fall = ~scl_s2 & scl_s3;
	wire       bus_start = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
	wire       bus_stop = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

	reg  [6:0]  own_addr;
	reg  [7:0]  operation;
	reg  [15:0] vout_cmd;
	reg  [15:0] fan_cmd;
	reg  [15:0] temp_word;
	reg  [15:0] fan1_word;
	reg  [15:0] fan2_word;
	reg  [23:0] rx_last;
	reg  [`PTF_IRQ_WIDTH-1:0] irq_status;
	reg  [`PTF_IRQ_WIDTH-1:0] irq_enable;
	reg        alarm_oc, alarm_sd, alarm_pec, alarm_uns;

	reg        in_frame, addr_phase, active, rd_mode, ack_me, master_ack, cmd_seen, rd_seen;
	reg  [3:0] bitcnt;
	reg  [7:0] shreg;
	reg  [7:0] txbyte;
	reg  [2:0] tx_idx;
	reg  [2:0] rx_cnt;
	reg  [7:0] cmd;
	reg  [7:0] rx_b1, rx_b2, rx_b3;

	wire [7:0] crc;
	wire [7:0] nbyte = {shreg[6:0], sda_s2};
	wire       byte_done = scl_rise & (bitcnt == 4'h7) & (addr_phase | active);
	wire       crc_clear = bus_start & ~in_frame;
	wire [2:0] wl = wr_len(cmd);
	wire [2:0] rl = rd_len(cmd);
	wire [2:0] dcnt = rx_cnt - 3'h1;
	wire       wr_end = bus_stop & in_frame & cmd_seen & ~rd_seen;
	wire       wr_unsup = wr_end & (wl == `PTF_LEN_NONE);
	wire       wr_full = wr_end & ~wr_unsup & (dcnt == wl + 3'h1);
	wire       wr_ok = wr_full & (crc == 8'h00);
	wire       wr_bad = (wr_full & (crc != 8'h00)) |
	                    (wr_end & ~wr_unsup & (dcnt != wl) & (dcnt != wl + 3'h1));
	wire       rd_start = byte_done & addr_phase & (nbyte[7:1] == own_addr) & nbyte[0];
	wire       rd_unsup = rd_start & (~cmd_seen | (rd_len(cmd) == `PTF_LEN_NONE));
	wire       clr_flt = wr_ok & (cmd == `PTF_CMD_CLEAR_FLT);
	wire [31:0] status_word;
	wire       bus_go = (avs_read | avs_write) & ~avs_waitrequest;
	wire       wr_go = avs_write & ~avs_waitrequest;
	wire [5:0] widx = avs_address[7:2];
	wire [`PTF_IRQ_WIDTH-1:0] irq_evt;
	wire [`PTF_IRQ_WIDTH-1:0] irq_clr;

	// two-flop release of the asynchronous reset
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end

	always @(posedge clock or negedge rstn_i) begin
		if (!rstn_i) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_s3 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_s3 <= 1'b1;
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
		end else begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
			pin_s1 <= remote_onoff_pin;
			pin_s2 <= pin_s1;
		end
	end

	ptf_crc8 u_crc (
		.clock (clock),
		.rst_n (rstn_i),
		.clear (crc_clear),
		.valid (byte_done),
		.data  (nbyte),
		.crc   (crc)
	); // [R15] [R3]

	// byte to send at a given read index; pec after the data, idle high beyond
	reg [7:0] tx_sel;
	always @* begin
		tx_sel = 8'hFF;
		if (rl == `PTF_LEN_NONE) begin
			tx_sel = (tx_idx == 3'h0) ? 8'h00 : (tx_idx == 3'h1) ? crc : 8'hFF; // [R18] [R11]
		end else if (tx_idx == rl) begin
			tx_sel = crc; // [R17] [R3]
		end else if (tx_idx < rl) begin
			case (cmd)
				`PTF_CMD_OPERATION: tx_sel = operation;
				`PTF_CMD_VOUT_MODE: tx_sel = `PTF_VOUT_MODE_VAL; // [R9]
				`PTF_CMD_VOUT_CMD:  tx_sel = tx_idx[0] ? vout_cmd[15:8] : vout_cmd[7:0]; // [R2]
				`PTF_CMD_TEMP:      tx_sel = tx_idx[0] ? temp_word[15:8] : temp_word[7:0]; // [R8]
				`PTF_CMD_FAN1:      tx_sel = tx_idx[0] ? fan1_word[15:8] : fan1_word[7:0];
				`PTF_CMD_FAN2:      tx_sel = tx_idx[0] ? fan2_word[15:8] : fan2_word[7:0];
				`PTF_CMD_ALARM_BLK: begin
					case (tx_idx)
						3'h0:    tx_sel = `PTF_ALARM_BLK_CNT; // [R5]
						3'h1:    tx_sel = status_word[7:0];
						3'h2:    tx_sel = status_word[15:8];
						3'h3:    tx_sel = status_word[23:16];
						default: tx_sel = status_word[31:24];
					endcase
				end
				default:            tx_sel = 8'h00;
			endcase
		end
	end

	// bus framing engine
	always @(posedge clock or negedge rstn_i) begin
		if (!rstn_i) begin
			in_frame   <= 1'b0;
			addr_phase <= 1'b0;
			active     <= 1'b0;
			rd_mode    <= 1'b0;
			ack_me     <= 1'b0;
			master_ack <= 1'b0;
			cmd_seen   <= 1'b0;
			rd_seen    <= 1'b0;
			bitcnt     <= 4'h0;
			shreg      <= 8'h00;
			txbyte     <= 8'hFF;
			tx_idx     <= 3'h0;
			rx_cnt     <= 3'h0;
			cmd        <= 8'h00;
			rx_b1      <= 8'h00;
			rx_b2      <= 8'h00;
			rx_b3      <= 8'h00;
			sda_out    <= 1'b0;
			sda_oe     <= 1'b0;
		end else if (bus_stop) begin
			in_frame   <= 1'b0;
			addr_phase <= 1'b0;
			active     <= 1'b0;
			sda_oe     <= 1'b0;
		end else if (bus_start) begin
			// a restart keeps the command and the running pec
			in_frame   <= 1'b1;
			addr_phase <= 1'b1;
			active     <= 1'b0;
			bitcnt     <= 4'h0;
			sda_oe     <= 1'b0;
			if (!in_frame) begin
				rx_cnt   <= 3'h0;
				cmd_seen <= 1'b0;
				rd_seen  <= 1'b0;
			end
		end else if (scl_rise) begin
			if (bitcnt < 4'h8) begin
				shreg  <= nbyte;
				bitcnt <= bitcnt + 4'h1;
			end else if (bitcnt == 4'h8) begin
				master_ack <= ~sda_s2; // [R4]
				bitcnt     <= 4'h9;
			end
			if (byte_done && addr_phase) begin
				addr_phase <= 1'b0;
				active     <= (nbyte[7:1] == own_addr);
				ack_me     <= (nbyte[7:1] == own_addr);
				rd_mode    <= nbyte[0];
				tx_idx     <= 3'h0;
				if (rd_start)
					rd_seen <= 1'b1;
			end else if (byte_done && !rd_mode) begin
				ack_me <= 1'b1;
				if (rx_cnt != 3'h7)
					rx_cnt <= rx_cnt + 3'h1;
				case (rx_cnt)
					3'h0:    cmd   <= nbyte;
					3'h1:    rx_b1 <= nbyte; // [R2]
					3'h2:    rx_b2 <= nbyte;
					3'h3:    rx_b3 <= nbyte;
					default: rx_b3 <= rx_b3;
				endcase
				if (rx_cnt == 3'h0)
					cmd_seen <= 1'b1;
			end
		end else if (scl_fall && active) begin
			if (bitcnt == 4'h8) begin
				sda_oe <= ack_me;
			end else if (bitcnt == 4'h9) begin
				bitcnt <= 4'h0;
				ack_me <= 1'b0;
				if (rd_mode && (ack_me || master_ack)) begin
					txbyte <= tx_sel;
					tx_idx <= tx_idx + 3'h1;
					sda_oe <= ~tx_sel[7];
				end else if (rd_mode) begin
					active <= 1'b0; // [R4]
					sda_oe <= 1'b0;
				end else begin
					sda_oe <= 1'b0;
				end
			end else if (rd_mode && bitcnt != 4'h0) begin
				sda_oe <= ~txbyte[3'h7 - bitcnt[2:0]];
			end
		end
	end

	// accepted writes; a frame without pec or with a bad pec changes nothing
	always @(posedge clock or negedge rstn_i) begin
		if (!rstn_i) begin
			operation <= `PTF_OPERATION_RST;
			vout_cmd  <= 16'h0000;
			fan_cmd   <= 16'h0000;
			rx_last   <= 24'h000000;
		end else if (wr_ok) begin // [R16] [R19] [R1]
			rx_last <= {rx_b2, rx_b1, cmd};
			case (cmd)
				`PTF_CMD_OPERATION: operation <= rx_b1;
				`PTF_CMD_VOUT_CMD:  vout_cmd  <= {rx_b2, rx_b1}; // [R9] [R2]
				`PTF_CMD_FAN_CMD:   fan_cmd   <= {rx_b2, rx_b1}; // [R6]
				default:            rx_last   <= {rx_b2, rx_b1, cmd};
			endcase
		end
	end

	// live bits follow the unit, alarm bits hold until clear_faults; set beats clear
	always @(posedge clock or negedge rstn_i) begin
		if (!rstn_i) begin
			alarm_oc  <= 1'b0;
			alarm_sd  <= 1'b0;
			alarm_pec <= 1'b0;
			alarm_uns <= 1'b0;
			output_on <= 1'b0;
		end else begin
			alarm_oc  <= overcurrent_fault_live | (alarm_oc & ~clr_flt); // [R13] [R14]
			alarm_sd  <= shutdown_live | (alarm_sd & ~clr_flt); // [R13] [R14]
			alarm_pec <= wr_bad | (alarm_pec & ~clr_flt); // [R19] [R14]
			alarm_uns <= wr_unsup | rd_unsup | (alarm_uns & ~clr_flt); // [R18] [R14]
			output_on <= operation[`PTF_OPER_ON_BIT] & pin_s2; // [R10] [R12]
		end
	end

	assign status_word = {{(32 - `PTF_ST_WIDTH){1'b0}}, pin_s2, alarm_uns, alarm_pec,
	                      alarm_sd, alarm_oc, output_on}; // [R12]

	assign irq_evt = {clr_flt, (overcurrent_fault_live & ~alarm_oc) | (shutdown_live & ~alarm_sd),
	                  wr_unsup | rd_unsup, wr_bad, wr_ok};
	assign irq_clr = (wr_go && widx == `PTF_REG_IRQ_CLEAR) ?
	                 avs_writedata[`PTF_IRQ_WIDTH-1:0] : {`PTF_IRQ_WIDTH{1'b0}};

	genvar g;
	generate
		for (g = 0; g < `PTF_IRQ_WIDTH; g = g + 1) begin : g_irq
			always @(posedge clock or negedge rstn_i) begin
				if (!rstn_i)
					irq_status[g] <= 1'b0;
				else
					irq_status[g] <= irq_evt[g] | (irq_status[g] & ~irq_clr[g]);
			end
		end
	endgenerate

	// avalon slave: one wait cycle, then the access commits at the edge waitrequest is low
	always @(posedge clock or negedge rstn_i) begin
		if (!rstn_i) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
			own_addr        <= `PTF_OWN_ADDR_RST;
			irq_enable      <= {`PTF_IRQ_WIDTH{1'b0}};
			temp_word       <= 16'h0000;
			fan1_word       <= 16'h0000;
			fan2_word       <= 16'h0000;
			irq             <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
			if (bus_go) begin
				avs_waitrequest <= 1'b1;
			end else if (avs_read || avs_write) begin
				avs_waitrequest <= 1'b0;
			end
			if ((avs_read || avs_write) && avs_waitrequest) begin
				case (widx)
					`PTF_REG_CTRL:       avs_readdata <= {25'h0000000, own_addr};
					`PTF_REG_STATUS:     avs_readdata <= status_word;
					`PTF_REG_IRQ_STATUS: avs_readdata <= {27'h0000000, irq_status};
					`PTF_REG_IRQ_ENABLE: avs_readdata <= {27'h0000000, irq_enable};
					`PTF_REG_RX_CMD:     avs_readdata <= {8'h00, rx_last};
					`PTF_REG_VOUT_VALUE: avs_readdata <= {7'h00, vout_cmd, 9'h000}; // [R9]
					`PTF_REG_FAN_RAW:    avs_readdata <= {16'h0000, fan_cmd};
					`PTF_REG_FAN_VALUE:  avs_readdata <= lin_value(fan_cmd); // [R7] [R6]
					`PTF_REG_TEMP:       avs_readdata <= {16'h0000, temp_word};
					`PTF_REG_FAN1:       avs_readdata <= {16'h0000, fan1_word};
					`PTF_REG_FAN2:       avs_readdata <= {16'h0000, fan2_word};
					`PTF_REG_OPERATION:  avs_readdata <= {24'h000000, operation};
					default:             avs_readdata <= 32'h00000000;
				endcase
			end
			if (wr_go) begin
				case (widx)
					`PTF_REG_CTRL:       own_addr   <= avs_writedata[6:0];
					`PTF_REG_IRQ_ENABLE: irq_enable <= avs_writedata[`PTF_IRQ_WIDTH-1:0];
					`PTF_REG_TEMP:       temp_word  <= avs_writedata[15:0];
					`PTF_REG_FAN1:       fan1_word  <= avs_writedata[15:0];
					`PTF_REG_FAN2:       fan2_word  <= avs_writedata[15:0];
					default:             own_addr   <= own_addr;
				endcase
			end
		end
	end

endmodule // ptf_target

// >>> sim/ptf_target_monitor.sv
// checker for ptf_target: avalon handshake, pin drive, output-on relations
// assumes it is bound to ptf_target and sees only that module's ports
`timescale 1ns/100ps
module ptf_target_monitor (
	input wire        clock,
	input wire        rst_n,
	input wire [7:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire        irq,
	input wire        scl_in,
	input wire        sda_out,
	input wire        sda_oe,
	input wire        remote_onoff_pin,
	input wire        output_on
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	answer_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered after one wait cycle");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	data_hold_a: assert property (!avs_read && !avs_write |=> $stable(avs_readdata))
		else $error("readdata changed without an access");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[7:2] > 6'h0C
		|-> avs_readdata == 32'h0) else $error("unmapped read not zero");
	open_drain_a: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	ack_drive_a: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("data pin taken while bus clock high");
	remote_off_a: assert property (!remote_onoff_pin [*4] |=> !output_on)
		else $error("output on while remote pin low");
	remote_on_a: assert property ($rose(output_on)
		|-> $past(remote_onoff_pin, 2) && $past(remote_onoff_pin, 3))
		else $error("output turned on without remote pin");
	irq_clear_a: assert property ($fell(irq)
		|-> $past(avs_write, 1) || $past(avs_write, 2) || $past(avs_write, 3))
		else $error("irq dropped without a register write");
endmodule // ptf_target_monitor

bind ptf_target ptf_target_monitor u_mon (.clock(clock), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.remote_onoff_pin(remote_onoff_pin), .output_on(output_on));

// >>> sim/ptf_host.sv
// host controller model: two-wire bus master with packet error check
// assumes the bench resolves the data wire with a pull-up; bit time 16 clocks
`timescale 1ns/100ps
module ptf_host (
	input  wire clock,
	input  wire sda,
	output reg  scl,
	output reg  m_oe
);
	reg [7:0] pec;
	reg       ack;
	initial begin
		scl = 1'b1;
		m_oe = 1'b0;
	end
	function [7:0] crc(input [7:0] c, input [7:0] d);
		integer i;
		reg [7:0] x;
		begin
			x = c ^ d;
			for (i = 0; i < 8; i = i + 1)
				x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
			crc = x;
		end
	endfunction
	// quarter of a bit time: clock stands still outside frames
	task qt;
		repeat (4) @(posedge clock);
	endtask
	task start;
		begin
			m_oe <= 1'b0; qt; scl <= 1'b1; qt; m_oe <= 1'b1; qt; scl <= 1'b0; qt;
		end
	endtask
	task stop;
		begin
			m_oe <= 1'b1; qt; scl <= 1'b1; qt; m_oe <= 1'b0; qt; qt;
		end
	endtask
	task bitx(input b, output r);
		begin
			m_oe <= !b; qt; scl <= 1'b1; qt; r = sda; qt; scl <= 1'b0; qt;
		end
	endtask
	task wbyte(input [7:0] d);
		integer i;
		reg     r;
		begin
			for (i = 7; i >= 0; i = i - 1)
				bitx(d[i], r);
			bitx(1'b1, ack);
			pec = crc(pec, d);
		end
	endtask
	task rbyte(input last, output [7:0] d);
		integer i;
		reg     r;
		begin
			for (i = 7; i >= 0; i = i - 1)
				bitx(1'b1, d[i]);
			bitx(last, r);
			pec = crc(pec, d);
		end
	endtask
	// mode 0 good check byte, 1 corrupted, 2 none
	task wr(input [7:0] cmd, input [1:0] n, input [15:0] v, input [1:0] mode);
		begin
			pec = 8'h00;
			start;
			wbyte(8'hB0);
			wbyte(cmd);
			if (n > 0) wbyte(v[7:0]);
			if (n > 1) wbyte(v[15:8]);
			if (mode != 2) wbyte(mode == 1 ? ~pec : pec);
			stop;
		end
	endtask
	task rd(input [7:0] cmd, input [2:0] n, output [39:0] v, output ok);
		integer i;
		reg [7:0] b;
		begin
			pec = 8'h00;
			v = 40'h0;
			start;
			wbyte(8'hB0);
			wbyte(cmd);
			start;
			wbyte(8'hB1);
			for (i = 0; i < n; i = i + 1) begin
				rbyte(1'b0, b);
				v = v | ({32'h0, b} << (8 * i));
			end
			rbyte(1'b1, b);
			ok = (pec == 8'h00);
			stop;
		end
	endtask
endmodule // ptf_host

// >>> sim/tb_pmbus_target_command_framing.sv
// self-checking bench for ptf_target through avalon and the host bus model
// assumes own address 0x58 and the register map of ptf_regs.vh
`timescale 1ns/100ps
module tb_pmbus_target_command_framing;
	reg         clock = 1'b0;
	reg         rst_n = 1'b0;
	reg  [7:0]  avs_address = 8'h00;
	reg         avs_read = 1'b0;
	reg         avs_write = 1'b0;
	reg  [31:0] avs_writedata = 32'h0;
	reg         remote = 1'b1;
	reg         oc = 1'b0;
	reg         sd = 1'b0;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	wire        irq;
	wire        scl;
	wire        m_oe;
	wire        sda_out;
	wire        sda_oe;
	wire        output_on;
	wire        sda_w = !(sda_oe | m_oe);
	integer     n_fail = 0;
	integer     total_checks = 0;
	integer     i;
	reg  [31:0] r;
	reg  [39:0] v;
	reg         ok;
	reg  [15:0] lin [0:1];
	reg  [31:0] lexp [0:1];
	reg  [7:0]  nrd [0:2];

	always #5 clock = ~clock;

	ptf_target u_dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.remote_onoff_pin(remote), .overcurrent_fault_live(oc), .shutdown_live(sd),
		.output_on(output_on));
	ptf_host u_host (.clock(clock), .sda(sda_w), .scl(scl), .m_oe(m_oe));

	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_fail);
			if (n_fail == 0 && total_checks > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("[FAIL] %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task av(input w, input [5:0] idx, input [31:0] d, output [31:0] q);
		integer k;
		begin
			@(posedge clock);
			avs_address <= {idx, 2'b00};
			avs_read <= !w;
			avs_write <= w;
			avs_writedata <= d;
			k = 0;
			@(posedge clock);
			while (avs_waitrequest && k < 50) begin
				@(posedge clock);
				k = k + 1;
			end
			q = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			if (k >= 50) begin
				n_fail = n_fail + 1;
				tally_and_finish;
			end
		end
	endtask
	task settle;
		begin
			repeat (3) @(posedge clock);
			@(negedge clock);
		end
	endtask

	initial begin
		lin[0] = 16'h1005; lexp[0] = 32'h14;
		lin[1] = 16'hF806; lexp[1] = 32'h03;
		nrd[0] = 8'h02; nrd[1] = 8'h19; nrd[2] = 8'h98;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		repeat (6) @(posedge clock);
		av(0, 6'h00, 0, r); chk("ctrl", 32'h58, r);
		av(0, 6'h01, 0, r); chk("status", 32'h20, r);
		av(0, 6'h0C, 0, r); chk("oper", 32'h0, r);
		av(1, 6'h03, 32'h1F, r);
		av(1, 6'h04, 32'h01, r);
		u_host.wr(8'h01, 1, 16'h0080, 0);
		av(0, 6'h0C, 0, r); chk("oper", 32'h80, r);
		settle; chk("out_on", 1, output_on); chk("irq", 1, irq);
		av(0, 6'h01, 0, r); chk("status", 32'h21, r);
		av(1, 6'h04, 32'h0, r); settle; chk("irq_mask", 0, irq);
		av(1, 6'h04, 32'h1, r); settle; chk("irq_en", 1, irq);
		av(1, 6'h03, 32'h1, r); settle; chk("irq_clr", 0, irq);
		u_host.wr(8'h01, 1, 16'h0000, 1);
		av(0, 6'h0C, 0, r); chk("oper", 32'h80, r);
		av(0, 6'h01, 0, r); chk("pec_err", 32'h08, r & 32'h08);
		u_host.wr(8'h01, 1, 16'h0000, 2);
		av(0, 6'h0C, 0, r); chk("oper", 32'h80, r);
		u_host.wr(8'h21, 2, 16'h1234, 0);
		av(0, 6'h06, 0, r); chk("vout", 32'h00246800, r);
		av(0, 6'h05, 0, r); chk("rx_cmd", 32'h00123421, r);
		u_host.rd(8'h21, 2, v, ok);
		chk("vout_rd", 32'h1234, v[31:0]); chk("rd_pec", 1, ok);
		for (i = 0; i < 2; i = i + 1) begin
			u_host.wr(8'h3B, 2, lin[i], 0);
			av(0, 6'h08, 0, r); chk("linear", lexp[i], r);
		end
		av(0, 6'h07, 0, r); chk("fan_raw", 32'hF806, r);
		u_host.rd(8'h20, 1, v, ok);
		chk("vmode", 32'h09, v[31:0]); chk("rd_pec", 1, ok);
		u_host.rd(8'h01, 1, v, ok);
		chk("oper_rd", 32'h80, v[31:0]); chk("rd_pec", 1, ok);
		for (i = 0; i < 3; i = i + 1) begin
			av(1, 6'h09 + i[5:0], 32'h0000ABCD + i, r);
			u_host.rd(8'h8F + i[7:0], 2, v, ok);
			chk("word", 32'hABCD + i, v[31:0]); chk("rd_pec", 1, ok);
		end
		for (i = 0; i < 3; i = i + 1) begin
			u_host.rd(nrd[i], 1, v, ok);
			chk("no_read", 32'h0, v[31:0]);
			chk("rd_pec", 1, ok);
			av(0, 6'h01, 0, r); chk("unsup", 32'h10, r & 32'h10);
		end
		u_host.rd(8'hD2, 5, v, ok);
		chk("count", 32'h04, {24'h0, v[7:0]}); chk("rd_pec", 1, ok);
		chk("blk", 32'h39, v[39:8]);
		oc <= 1'b1; repeat (3) @(posedge clock);
		oc <= 1'b0; repeat (3) @(posedge clock);
		av(0, 6'h01, 0, r); chk("latch", 32'h3B, r);
		sd <= 1'b1;
		u_host.wr(8'h03, 0, 16'h0, 0);
		av(0, 6'h01, 0, r); chk("clr_flt", 32'h25, r);
		u_host.wr(8'h01, 2, 16'h0000, 0);
		av(0, 6'h0C, 0, r); chk("oper", 32'h80, r);
		u_host.wr(8'h19, 0, 16'h0, 0);
		sd <= 1'b0;
		remote <= 1'b0;
		settle; chk("out_on", 0, output_on);
		av(0, 6'h01, 0, r); chk("status", 32'h1C, r);
		av(0, 6'h02, 0, r); chk("irq_stat", 32'h1F, r);
		av(0, 6'h3F, 0, r); chk("unmapped", 32'h0, r);
		tally_and_finish;
	end
endmodule // tb_pmbus_target_command_framing
